// *** include/erru_pkg.sv ***
// Package of constants and types for the error record update block.
package erru_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_FAULT_ADDR = 4'h4;
  localparam logic [3:0] ADDR_EXTRA0 = 4'h8;
  localparam logic [3:0] ADDR_EXTRA1 = 4'hC;
  localparam logic [3:0] ADDR_FEATURE = 4'h1;
  localparam logic [3:0] ADDR_CONTROL = 4'h2;

  // ----------------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------------
  localparam int ST_ARCH_LSB = 0;
  localparam int ST_IMPL_LSB = 8;
  localparam int ST_UET_LSB = 20;
  localparam int ST_POISON = 22;
  localparam int ST_CE_LSB = 24;
  localparam int ST_DEFER = 26;
  localparam int ST_MV = 27;
  localparam int ST_OF = 28;
  localparam int ST_ABORT = 29;
  localparam int ST_UE = 30;
  localparam int ST_V = 31;
  localparam int ST_AV = 19;

  // ----------------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] CE_NONE = 2'h0;
  localparam logic [1:0] CE_TRANSIENT = 2'h1;
  localparam logic [1:0] CE_FIRST = 2'h2;
  localparam logic [1:0] CE_PERSISTENT = 2'h3;
  localparam logic [1:0] UET_RESTART = 2'h2;
  localparam logic [1:0] UET_RECOVER = 2'h3;
  localparam logic [1:0] UET_UNRECOV = 2'h1;
  localparam logic [1:0] UET_UNCONT = 2'h0;
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [6:0] CNT_MAX = 7'h7F;
  localparam int CNT_OF_BIT = 7;
  localparam int CTL_CFI = 0;
  localparam int CTL_WIDE = 1;

  // Error class, ordered by priority.
  typedef enum logic [2:0] {
    ERRU_NONE = 3'b000,
    ERRU_CE = 3'b001,
    ERRU_DE = 3'b010,
    ERRU_UEO = 3'b011,
    ERRU_UER = 3'b100,
    ERRU_UEU = 3'b101,
    ERRU_UC = 3'b110
  } erru_class_t;

  // Overwrite actions.
  typedef enum logic [2:0] {
    ERRU_K = 3'b000,
    ERRU_O = 3'b001,
    ERRU_W = 3'b010,
    ERRU_WO = 3'b011,
    ERRU_CK = 3'b100,
    ERRU_CWK = 3'b101,
    ERRU_CW = 3'b110
  } erru_act_t;

endpackage : erru_pkg

// *** logic/erru_record.sv ***
// Error record update logic for one error-reporting node.
module erru_record
  import erru_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Error report from the detectors, same clock domain.
  input wire logic i_err_valid,
  input wire logic [2:0] i_err_class,
  input wire logic i_err_same_loc,
  input wire logic i_err_abort,
  input wire logic i_err_poison,
  input wire logic [7:0] i_err_arch_code,
  input wire logic [7:0] i_err_impl_code,
  input wire logic i_err_has_addr,
  input wire logic [31:0] i_err_addr,
  input wire logic i_err_has_misc,
  input wire logic [31:0] i_err_misc1,
  // Register port.
  input wire logic [3:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // Fault handling interrupt.
  output logic o_fault_irq
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  // The record is four words: status, fault address and the two extra
  // syndrome words. The counter of corrected errors lives in the low half
  // of the first extra syndrome word, so a software write there also
  // presets the counter; this lets software arm an early overflow.
  // The seen flag remembers that an error arrived after the last status
  // read. It guards the valid bit against a clear by software that acts
  // on an out-of-date view of the record.
  logic [31:0] status_reg;
  logic [31:0] status_next;
  logic [31:0] addr_reg;
  logic [31:0] addr_next;
  logic [31:0] extra0_reg;
  logic [31:0] extra0_next;
  logic [31:0] extra1_reg;
  logic [31:0] extra1_next;
  logic [1:0] control_reg;
  logic seen_reg;
  logic seen_next;
  logic policy_reg;
  logic [31:0] rdata_reg;
  logic irq_reg;
  erru_class_t prev_cls;
  erru_class_t new_cls;
  erru_act_t act;
  logic cnt_ovf;
  logic wr_status;

  // Class of the record from its status fields.
  // The uncorrected bit outranks the deferred bit, which outranks the
  // corrected field, so bits left over from older errors never hide the
  // highest recorded class.
  function automatic erru_class_t decode_class(input logic [31:0] st);
    erru_class_t c;
    c = ERRU_NONE;
    if (!st[ST_V]) begin
      c = ERRU_NONE;
    end else if (st[ST_UE]) begin
      unique case (st[ST_UET_LSB +: 2])
        UET_RESTART: c = ERRU_UEO;
        UET_RECOVER: c = ERRU_UER;
        UET_UNRECOV: c = ERRU_UEU;
        UET_UNCONT: c = ERRU_UC;
      endcase
    end else if (st[ST_DEFER]) begin
      c = ERRU_DE;
    end else if (st[ST_CE_LSB +: 2] != CE_NONE) begin
      c = ERRU_CE;
    end
    return c;
  endfunction : decode_class

  // Subtype code of an uncorrected class.
  function automatic logic [1:0] uet_code(input erru_class_t c);
    logic [1:0] u;
    u = UET_UNCONT;
    unique case (c)
      ERRU_UEO: u = UET_RESTART;
      ERRU_UER: u = UET_RECOVER;
      ERRU_UEU: u = UET_UNRECOV;
      default: u = UET_UNCONT;
    endcase
    return u;
  endfunction : uet_code

  // Priority matrix lookup.
  // The class codes grow with priority, so among uncorrected classes a
  // plain comparison tells a higher new error from an equal or lower one.
  // A deferred error after an uncorrected one keeps the record without
  // touching the overflow flag; an equal deferred error sets it.
  function automatic erru_act_t lookup(input erru_class_t p,
                                       input erru_class_t n);
    erru_act_t a;
    a = ERRU_W;
    if (p == ERRU_NONE) begin
      a = (n == ERRU_CE) ? ERRU_CW : ERRU_W;
    end else if (p == ERRU_CE) begin
      a = (n == ERRU_CE) ? ERRU_CWK : ERRU_W;
    end else if (n == ERRU_CE) begin
      a = ERRU_CK;
    end else if (p == ERRU_DE) begin
      a = (n == ERRU_DE) ? ERRU_O : ERRU_W;
    end else if (n == ERRU_DE) begin
      a = ERRU_K;
    end else if (n > p) begin
      a = ERRU_WO;
    end else begin
      a = ERRU_O;
    end
    return a;
  endfunction : lookup

  // ----------------------------------------------------------------------
  // Update decision
  // ----------------------------------------------------------------------
  // Simultaneous errors are merged by the detectors into one report of the
  // highest priority, so only one error is recorded per cycle.
  assign prev_cls = decode_class(status_reg);
  assign new_cls = erru_class_t'(i_err_class);
  assign act = lookup(prev_cls, new_cls);
  // Counter overflow: narrow or wide counter format.
  assign cnt_ovf = control_reg[CTL_WIDE] ?
                   (extra0_reg[14:0] == 15'h7FFF) :
                   (extra0_reg[6:0] == CNT_MAX);
  assign wr_status = i_reg_wr && (i_reg_addr == ADDR_STATUS);

  // Next record state from the new error and software writes.
  // Software effects are applied first and the error update on top of
  // them, so an error that lands in the same cycle as a clear always
  // survives it: the set wins over the clear.
  // The action itself is chosen from the registered status, which is the
  // record as it stood before this cycle.
  always_comb begin
    logic replace;
    logic set_of;
    replace = 1'b0;
    set_of = 1'b0;
    status_next = status_reg;
    addr_next = addr_reg;
    extra0_next = extra0_reg;
    extra1_next = extra1_reg;
    seen_next = seen_reg;
    if (i_reg_rd && (i_reg_addr == ADDR_STATUS)) begin
      seen_next = 1'b0;
    end
    // Software write-one-to-clear of status; a stale clear of valid is
    // refused, and a new error in the same cycle wins over the clear.
    if (wr_status) begin
      // A clear of valid is also refused while an error is being taken,
      // since software cannot have read that error yet.
      if (i_reg_wdata[ST_V] && !seen_reg &&
          !(i_err_valid && (new_cls != ERRU_NONE))) begin
        status_next = ZERO32;
      end else begin
        status_next = status_reg & ~(i_reg_wdata & ~(32'h1 << ST_V));
      end
    end
    if (i_reg_wr && (i_reg_addr == ADDR_EXTRA0)) begin
      extra0_next = i_reg_wdata;
    end
    if (i_reg_wr && (i_reg_addr == ADDR_EXTRA1)) begin
      extra1_next = i_reg_wdata;
    end
    if (i_err_valid && (new_cls != ERRU_NONE)) begin
      seen_next = 1'b1;
      unique case (act)
        ERRU_K: replace = 1'b0;
        ERRU_O: set_of = 1'b1;
        ERRU_W: replace = 1'b1;
        ERRU_WO: begin
          replace = 1'b1;
          set_of = 1'b1;
        end
        ERRU_CK: set_of = cnt_ovf;
        ERRU_CWK: begin
          if (policy_reg) begin
            replace = !status_reg[ST_OF];
          end
          set_of = cnt_ovf;
        end
        ERRU_CW: begin
          replace = 1'b1;
          set_of = cnt_ovf;
        end
        default: replace = 1'b0;
      endcase
      // Counter in the first extra syndrome register, sticky overflow.
      if (new_cls == ERRU_CE) begin
        if (control_reg[CTL_WIDE]) begin
          extra0_next[14:0] = extra0_reg[14:0] + 15'h1;
          extra0_next[15] = extra0_reg[15] | cnt_ovf;
        end else begin
          extra0_next[6:0] = extra0_reg[6:0] + 7'h1;
          extra0_next[CNT_OF_BIT] = extra0_reg[CNT_OF_BIT] | cnt_ovf;
        end
      end
      // Type bits are always updated, even when the syndrome is kept.
      unique case (new_cls)
        ERRU_CE: begin
          if (status_next[ST_CE_LSB +: 2] == CE_NONE) begin
            status_next[ST_CE_LSB +: 2] = CE_FIRST;
          end else begin
            status_next[ST_CE_LSB +: 2] = i_err_same_loc ?
                                          CE_PERSISTENT : CE_TRANSIENT;
          end
        end
        ERRU_DE: status_next[ST_DEFER] = 1'b1;
        default: status_next[ST_UE] = 1'b1;
      endcase
      if (set_of) begin
        status_next[ST_OF] = 1'b1;
      end
      if (replace) begin
        // Subtype reported exactly; no coarsening is applied.
        if (new_cls >= ERRU_UEO) begin
          status_next[ST_UET_LSB +: 2] = uet_code(new_cls);
        end else begin
          status_next[ST_UET_LSB +: 2] = UET_UNCONT;
        end
        status_next[ST_ABORT] = i_err_abort;
        status_next[ST_POISON] = i_err_poison;
        status_next[ST_ARCH_LSB +: 8] = i_err_arch_code;
        status_next[ST_IMPL_LSB +: 8] = i_err_impl_code;
        status_next[ST_AV] = i_err_has_addr;
        if (i_err_has_addr) begin
          addr_next = i_err_addr;
        end
        // Extra content is loaded only when the new error has it; MV follows i_err_has_misc.
        status_next[ST_MV] = i_err_has_misc;
        if (i_err_has_misc) begin
          extra1_next = i_err_misc1;
        end
        status_next[ST_V] = 1'b1;
      end else if (i_err_has_misc) begin
        extra1_next = i_err_misc1;
        status_next[ST_MV] = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Record registers.
  // The record is cleared only by the system reset; no other reset source
  // reaches it, so the syndrome survives for diagnosis.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      status_reg <= STATUS_RST;
      addr_reg <= ZERO32;
      extra0_reg <= ZERO32;
      extra1_reg <= ZERO32;
      seen_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      addr_reg <= addr_next;
      extra0_reg <= extra0_next;
      extra1_reg <= extra1_next;
      seen_reg <= seen_next;
    end
  end

  // Control: interrupt enable, counter width, and overwrite policy.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      control_reg <= 2'h0;
      policy_reg <= 1'b0;
    end else if (i_reg_wr && (i_reg_addr == ADDR_CONTROL)) begin
      control_reg <= i_reg_wdata[1:0];
      policy_reg <= i_reg_wdata[2];
    end
  end

  // Read data, one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_reg <= ZERO32;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        ADDR_STATUS: rdata_reg <= status_reg;
        ADDR_FAULT_ADDR: rdata_reg <= addr_reg;
        ADDR_EXTRA0: rdata_reg <= extra0_reg;
        ADDR_EXTRA1: rdata_reg <= extra1_reg;
        ADDR_FEATURE: rdata_reg <= {31'h0, policy_reg};
        ADDR_CONTROL: rdata_reg <= {29'h0, policy_reg, control_reg};
        default: rdata_reg <= ZERO32;
      endcase
    end else begin
      rdata_reg <= ZERO32;
    end
  end

  // Level interrupt while valid and the sticky counter overflow is set.
  // It is computed from the next record state so that it changes on the
  // same edge as the status word and never lags the record by a cycle.
  // Deferred and uncorrected errors raise this output only by setting valid while the counter overflow is already set.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= control_reg[CTL_CFI] && status_next[ST_V] &&
                 (control_reg[CTL_WIDE] ? extra0_next[15] :
                  extra0_next[CNT_OF_BIT]);
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_fault_irq = irq_reg;

endmodule : erru_record

// *** verif/erru_chk.sv ***
// Port checker for the error record update block.
// ---------------------------------------------------------------
// Port assertions
// ---------------------------------------------------------------
module erru_chk
  import erru_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Error report.
  input wire logic i_err_valid,
  input wire logic [2:0] i_err_class,
  // Register port and interrupt.
  input wire logic [3:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [31:0] o_reg_rdata,
  input wire logic o_fault_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // A taken error is visible in the very next status read.
  property p_valid_set;
    i_err_valid && i_err_class != 3'h0 ##1
      i_reg_rd && i_reg_addr == ADDR_STATUS |=> o_reg_rdata[ST_V];
  endproperty
  a_valid_set: assert property (p_valid_set)
    else $error("valid bit missing after error");
  property p_defer_bit;
    i_err_valid && i_err_class == 3'h2 ##1
      i_reg_rd && i_reg_addr == ADDR_STATUS |=> o_reg_rdata[ST_DEFER];
  endproperty
  a_defer_bit: assert property (p_defer_bit)
    else $error("postponed bit missing after deferred error");
  property p_uncorr_bit;
    i_err_valid && i_err_class >= 3'h3 && i_err_class <= 3'h6 ##1
      i_reg_rd && i_reg_addr == ADDR_STATUS |=> o_reg_rdata[ST_UE];
  endproperty
  a_uncorr_bit: assert property (p_uncorr_bit)
    else $error("uncorrectable bit missing after error");
  property p_ce_field;
    i_err_valid && i_err_class == 3'h1 ##1
      i_reg_rd && i_reg_addr == ADDR_STATUS |=>
      o_reg_rdata[ST_CE_LSB+1:ST_CE_LSB] != CE_NONE;
  endproperty
  a_ce_field: assert property (p_ce_field)
    else $error("corrected field zero after corrected error");
  property p_count_up;
    i_err_valid && i_err_class == 3'h1 ##1
      i_reg_rd && i_reg_addr == ADDR_EXTRA0 |=> o_reg_rdata[15:0] != 16'h0;
  endproperty
  a_count_up: assert property (p_count_up)
    else $error("counter zero after corrected error");
  // With no write between two status reads the valid bit cannot drop.
  property p_valid_holds;
    i_reg_rd && i_reg_addr == ADDR_STATUS ##1
      i_reg_rd && i_reg_addr == ADDR_STATUS && o_reg_rdata[ST_V]
      |=> o_reg_rdata[ST_V];
  endproperty
  a_valid_holds: assert property (p_valid_holds)
    else $error("valid bit dropped without a write");
  property p_irq_rise;
    $rose(o_fault_irq) |-> $past(i_err_valid) || $past(i_err_valid, 2)
      || $past(i_reg_wr) || $past(i_reg_wr, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("interrupt rose without a cause");
  property p_irq_fall;
    $fell(o_fault_irq) |-> $past(i_reg_wr) || $past(i_reg_wr, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt fell without a register write");
endmodule : erru_chk

bind erru_record erru_chk i_erru_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_err_valid(i_err_valid), .i_err_class(i_err_class),
  .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .o_fault_irq(o_fault_irq));

// *** verif/erru_detector.sv ***
// Model of the error detectors that feed one error record.
// ---------------------------------------------------------------
// Detector model
// ---------------------------------------------------------------
module erru_detector
  import erru_pkg::*;
(
  // Clock.
  input wire logic i_clk,
  // Error report, at most one per cycle.
  output logic o_err_valid,
  output logic [2:0] o_err_class,
  output logic o_err_same_loc,
  output logic o_err_abort,
  output logic o_err_poison,
  output logic [7:0] o_err_arch_code,
  output logic [7:0] o_err_impl_code,
  output logic o_err_has_addr,
  output logic [31:0] o_err_addr,
  output logic o_err_has_misc,
  output logic [31:0] o_err_misc1
);
  timeunit 1ns;
  timeprecision 1ns;
  logic go = 1'b0;
  logic v_q = 1'b0;
  logic [2:0] c_h = 3'h0;
  logic [2:0] c_q = 3'h0;
  logic [2:0] f_h = 3'h0;
  logic [2:0] f_q = 3'h0;
  logic [31:0] r_h = 32'h0;
  logic [31:0] r_q = 32'h0;
  // Payload fields other than the three flags all come from one word so the bench can predict them.
  assign o_err_valid = v_q;
  assign o_err_class = c_q;
  assign o_err_same_loc = f_q[0];
  assign o_err_has_addr = f_q[1];
  assign o_err_has_misc = f_q[2];
  assign o_err_abort = r_q[16];
  assign o_err_poison = r_q[17];
  assign o_err_arch_code = r_q[7:0];
  assign o_err_impl_code = r_q[15:8];
  assign o_err_addr = r_q;
  assign o_err_misc1 = ~r_q;
  // Idle payload toggles every cycle so a stale capture cannot pass.
  always @(posedge i_clk) begin
    v_q <= go;
    c_q <= go ? c_h : 3'h0;
    f_q <= go ? f_h : 3'h0;
    r_q <= go ? r_h : ~r_q;
  end
  // One report pulse; returns at the edge where the block takes it.
  task automatic report(input logic [2:0] c, input logic [2:0] f,
                        input logic [31:0] r);
    c_h <= c;
    f_h <= f;
    r_h <= r;
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    @(posedge i_clk);
  endtask : report
endmodule : erru_detector

// *** verif/erru_record_test.sv ***
// Self-checking testbench of the error record update block.
// ---------------------------------------------------------------
// Bench top
// ---------------------------------------------------------------
module erru_record_test;
  timeunit 1ns;
  timeprecision 1ns;
  import erru_pkg::*;
  localparam logic [31:0] V = 32'h1 << ST_V;
  localparam logic [31:0] UE = 32'h1 << ST_UE;
  localparam logic [31:0] OF = 32'h1 << ST_OF;
  localparam logic [31:0] DE = 32'h1 << ST_DEFER;
  localparam logic [31:0] AM = (32'h1 << ST_AV) | (32'h1 << ST_MV);
  localparam logic [31:0] SM = 32'hFF78_FFFF;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [3:0] i_reg_addr = 4'h0;
  logic [31:0] i_reg_wdata = 32'h0;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic rd_q = 1'b0;
  logic [31:0] o_reg_rdata;
  logic o_fault_irq;
  logic e_v, e_s, e_a, e_p, e_h, e_m;
  logic [2:0] e_c;
  logic [7:0] e_ac, e_ic;
  logic [31:0] e_ad, e_mi, seed, r, rec, m_cur;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int err_total = 0;
  int check_count = 0;

  erru_detector i_erru_detector (.i_clk(i_clk), .o_err_valid(e_v),
    .o_err_class(e_c), .o_err_same_loc(e_s), .o_err_abort(e_a),
    .o_err_poison(e_p), .o_err_arch_code(e_ac), .o_err_impl_code(e_ic),
    .o_err_has_addr(e_h), .o_err_addr(e_ad), .o_err_has_misc(e_m),
    .o_err_misc1(e_mi));
  erru_record i_erru_record (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_err_valid(e_v), .i_err_class(e_c), .i_err_same_loc(e_s),
    .i_err_abort(e_a), .i_err_poison(e_p), .i_err_arch_code(e_ac),
    .i_err_impl_code(e_ic), .i_err_has_addr(e_h), .i_err_addr(e_ad),
    .i_err_has_misc(e_m), .i_err_misc1(e_mi), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_fault_irq(o_fault_irq));

  // Free-running 50 MHz clock.
  always #10 i_clk = ~i_clk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // Expected status word from flags plus the recorded syndrome word.
  function automatic logic [31:0] st(input logic [31:0] f,
                                     input logic [1:0] ce, input logic [1:0] u);
    return f | {2'h0, rec[16], 3'h0, ce, 1'b0, rec[17], u, 4'h0, rec[15:0]};
  endfunction : st
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic conclude();
    if (exp_q.size() != 0) err_total++;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  // Strobes stay up between back-to-back accesses; err releases them.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    i_reg_wr <= 1'b1;
    i_reg_rd <= 1'b0;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    i_reg_rd <= 1'b1;
    i_reg_wr <= 1'b0;
    i_reg_addr <= a;
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge i_clk);
  endtask : rd
  task automatic err(input logic [2:0] c, input logic [2:0] f,
                     input logic w);
    r = xs();
    if (w) rec = r;
    i_reg_rd <= 1'b0;
    i_reg_wr <= 1'b0;
    i_erru_detector.report(c, f, r);
  endtask : err
  task automatic irq(input logic e);
    i_reg_rd <= 1'b0;
    i_reg_wr <= 1'b0;
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    chk("irq", {31'h0, o_fault_irq}, {31'h0, e});
    @(posedge i_clk);
  endtask : irq

  // Each read answer is matched with the oldest expectation.
  always @(posedge i_clk) begin
    rd_q <= i_reg_rd;
    if (rd_q && exp_q.size() > 0) begin
      m_cur = msk_q.pop_front();
      chk("rdata", o_reg_rdata & m_cur, exp_q.pop_front());
    end
  end

  // Main sequence walks the overwrite matrix from an empty record.
  initial begin
    seed = 32'h0000_9FFE;
    rec = 32'h0;
    repeat (6) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    rd(ADDR_STATUS, 32'h0, SM);
    rd(4'h3, 32'h0, 32'hFFFF_FFFF);
    wr(ADDR_CONTROL, 32'h1);
    err(3'h1, 3'h6, 1'b1);
    rd(ADDR_STATUS, st(V | AM, CE_FIRST, 2'h0), SM);
    rd(ADDR_FAULT_ADDR, rec, 32'hFFFF_FFFF);
    rd(ADDR_EXTRA1, ~rec, 32'hFFFF_FFFF);
    rd(ADDR_EXTRA0, 32'h1, 32'hFF);
    err(3'h1, 3'h1, 1'b0);
    rd(ADDR_STATUS, st(V | AM, CE_PERSISTENT, 2'h0), SM);
    err(3'h2, 3'h0, 1'b1);
    rd(ADDR_STATUS, st(V | DE, CE_PERSISTENT, 2'h0), SM);
    err(3'h2, 3'h0, 1'b0);
    rd(ADDR_STATUS, st(V | DE | OF, CE_PERSISTENT, 2'h0), SM);
    err(3'h3, 3'h6, 1'b1);
    rd(ADDR_STATUS, st(V | DE | OF | UE | AM, CE_PERSISTENT, UET_RESTART),
       SM);
    wr(ADDR_STATUS, OF);
    err(3'h4, 3'h0, 1'b1);
    rd(ADDR_STATUS, st(V | DE | OF | UE, CE_PERSISTENT, UET_RECOVER),
       SM);
    wr(ADDR_STATUS, OF);
    err(3'h2, 3'h0, 1'b0);
    rd(ADDR_STATUS, st(V | DE | UE, CE_PERSISTENT, UET_RECOVER), SM);
    err(3'h3, 3'h2, 1'b0);
    rd(ADDR_STATUS, st(V | DE | UE | OF, CE_PERSISTENT, UET_RECOVER),
       SM);
    err(3'h1, 3'h0, 1'b0);
    rd(ADDR_EXTRA0, 32'h3, 32'hFF);
    wr(ADDR_STATUS, V);
    rd(ADDR_STATUS, V, V);
    rd(ADDR_STATUS, V, V);
    wr(ADDR_STATUS, 32'hFFFF_FFFF);
    rd(ADDR_STATUS, 32'h0, SM);
    wr(ADDR_EXTRA0, 32'h7F);
    err(3'h1, 3'h0, 1'b1);
    rd(ADDR_EXTRA0, 32'h80, 32'hFF);
    rd(ADDR_STATUS, st(V | OF, CE_FIRST, 2'h0), SM);
    irq(1'b1);
    wr(ADDR_STATUS, 32'hFFFF_FFFF);
    irq(1'b0);
    wr(ADDR_CONTROL, 32'h3);
    wr(ADDR_EXTRA0, 32'h7FFF);
    err(3'h1, 3'h0, 1'b0);
    rd(ADDR_EXTRA0, 32'h8000, 32'hFFFF);
    irq(1'b1);
    wr(ADDR_STATUS, 32'hFFFF_FFFF);
    rd(ADDR_STATUS, V, 32'hFFFF_FFFF);
    wr(ADDR_STATUS, 32'hFFFF_FFFF);
    wr(ADDR_CONTROL, 32'h4);
    rd(ADDR_FEATURE, 32'h1, 32'hFFFF_FFFF);
    err(3'h1, 3'h0, 1'b1);
    err(3'h1, 3'h6, 1'b1);
    rd(ADDR_STATUS, st(V | AM, CE_TRANSIENT, 2'h0), SM);
    irq(1'b0);
    conclude();
  end

  // Watchdog in case the sequence hangs.
  initial begin
    repeat (3000) @(posedge i_clk);
    err_total++;
    conclude();
  end
endmodule : erru_record_test
